// File: rrd_regs.sv
// Purpose: Regulator control, regulator/timer display and peak signal
//          strength registers of an HF reader front end.
// Assumes: Timer, receiver and command inputs are on the same clock.
// Notes:   Read data appear one cycle after the read strobe.
`timescale 1ns/1ps

// Function
// [R1] Control bit 7 picks adjust result (0) or software code (1).
// [R2] Control bits 6:3 hold the software regulator code.
// [R3] Control bits 2:1 select supply for power measurement.
// [R4] Control register clears at reset and set-default.
// [R5] Display bits 7:4 show the effective regulator code.
// [R6] Effective code is all ones after reset or set-default.
// [R7] Valid codes are 0101 to 1111; lower codes unused.
// [R8] Display bit 2 shows general purpose timer running.
// [R9] Display bit 1 shows no-response timer running.
// [R10] Display bit 0 shows mask receive timer running.
// [R11] Signal strength bits 7:4 hold amplitude channel peak.
// [R12] Signal strength bits 3:0 hold phase channel peak.
// [R13] Peaks clear at message start and on clear command.
// [R14] Signal strength register is zero after reset and set-default.
// [R15] Auxiliary bit 7 shows which channel value logic uses.
// [R16] Codes rise monotonically with received amplitude.
// [R17] Control register is readable and writable.
// [R18] Signal strength register ignores writes.
// [R19] Channel select bit reads 0 for amplitude, 1 for phase.
// [R20] Each peak updates only when a new code is larger.
// [R21] Display is read-only, bit 3 zero; control bit 0 reads zero.
module rrd_regs
   import rrd_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Host register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   // Commands and events
   input wire logic set_default,
   input wire logic clear_rssi,
   input wire logic msg_start,
   input wire logic adjust_done,
   input wire logic [3:0] adjust_code,
   // Receiver measurements
   input wire logic amp_valid,
   input wire logic [3:0] amp_code,
   input wire logic phase_valid,
   input wire logic [3:0] phase_code,
   input wire logic phase_chan_sel,
   // Timer status
   input wire logic gpt_running,
   input wire logic nrt_running,
   input wire logic mrt_running,
   // Regulator outputs
   output logic [3:0] reg_code,
   output logic [1:0] measure_supply_select
);

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   logic [7:0] ctrl;
   logic [3:0] adj_code;
   logic ctrl_wr;
   logic [7:0] disp_val;
   logic [7:0] rssi_val;
   logic [3:0] amplitude_chan_peak;
   logic [3:0] phase_chan_peak;
   logic [2:0] timers;
   logic chan_sel;
   logic [3:0] next_reg_code;

   function automatic logic [3:0] peak_of(input logic [3:0] cur,
                                          input logic [3:0] smp,
                                          input logic vld);
      peak_of = (vld && smp > cur) ? smp : cur;
   endfunction : peak_of

   assign ctrl_wr = wr && addr == REG_CTRL_OFS;

   always_ff @(posedge clock) begin
      if (!rst_n || set_default) begin
         ctrl <= CTRL_RESET; // R4
      end else if (ctrl_wr) begin
         ctrl <= {wdata[7:1], 1'b0}; // R17 R21
      end
   end

   // ------------------------------------------------------------
   // Regulator code selection
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n || set_default) begin
         adj_code <= REG_CODE_MAX; // R6
      end else if (adjust_done) begin
         adj_code <= adjust_code;
      end
   end

   // Codes below the minimum are unused; software is expected to avoid them.
   always_comb begin
      if (ctrl[CTRL_SRC_BIT]) begin
         next_reg_code = ctrl[CTRL_CODE_HI:CTRL_CODE_LO]; // R1 R2 R7
      end else begin
         next_reg_code = adj_code; // R1
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n || set_default) begin
         reg_code <= REG_CODE_MAX; // R6
         measure_supply_select <= MEAS_MAIN;
      end else begin
         reg_code <= next_reg_code; // R5
         measure_supply_select <= ctrl[CTRL_MEAS_HI:CTRL_MEAS_LO]; // R3
      end
   end

   // ------------------------------------------------------------
   // Timer flags and channel select
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         timers <= 3'h0;
         chan_sel <= 1'b0;
      end else begin
         timers <= {gpt_running, nrt_running, mrt_running}; // R8 R9 R10
         chan_sel <= phase_chan_sel; // R15 R19
      end
   end

   // ------------------------------------------------------------
   // Peak signal strength
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n || set_default || clear_rssi || msg_start) begin
         amplitude_chan_peak <= 4'h0; // R13 R14
         phase_chan_peak <= 4'h0; // R13 R14
      end else begin
         amplitude_chan_peak <= peak_of(amplitude_chan_peak, amp_code,
                                        amp_valid); // R11 R16 R20
         phase_chan_peak <= peak_of(phase_chan_peak, phase_code,
                                    phase_valid); // R12 R16 R20
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   assign disp_val = {reg_code, 1'b0, timers}; // R5 R21
   assign rssi_val = {amplitude_chan_peak, phase_chan_peak}; // R11 R12 R18

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            REG_CTRL_OFS: rdata <= ctrl; // R17
            REG_DISP_OFS: rdata <= disp_val;
            REG_RSSI_OFS: rdata <= rssi_val;
            REG_AUX_OFS: rdata <= {chan_sel, 7'h00}; // R15
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_ctrl_reset_clear: assert property (@(posedge clock) // R4
      (!rst_n || set_default) |=> ctrl == 8'h00)
      else $error("control register not cleared");
   a_ctrl_bit0_zero: assert property (@(posedge clock) // R21
      disable iff (!rst_n) ctrl[0] == 1'b0)
      else $error("control bit 0 set");
   a_src_manual: assert property (@(posedge clock) disable iff (!rst_n) // R1
      (ctrl[7] && !set_default) |=> reg_code == $past(ctrl[6:3]))
      else $error("manual code not applied");
   a_code_default: assert property (@(posedge clock) // R6
      (!rst_n || set_default) |=> reg_code == 4'hF)
      else $error("default code not maximum");
   a_meas_follow: assert property (@(posedge clock) disable iff (!rst_n) // R3
      !set_default |=> measure_supply_select == $past(ctrl[2:1]))
      else $error("measure select mismatch");
   a_peak_clear: assert property (@(posedge clock) // R13
      (clear_rssi || msg_start) |=> rssi_val == 8'h00)
      else $error("peaks not cleared");
   a_peak_mono: assert property (@(posedge clock) disable iff (!rst_n) // R20
      !(set_default || clear_rssi || msg_start)
      |=> amplitude_chan_peak >= $past(amplitude_chan_peak)
       && phase_chan_peak >= $past(phase_chan_peak))
      else $error("peak decreased");
   a_rssi_nowrite: assert property (@(posedge clock) disable iff (!rst_n) // R18
      (wr && addr == REG_RSSI_OFS && !amp_valid && !phase_valid && !clear_rssi
       && !msg_start && !set_default) |=> $stable(rssi_val))
      else $error("write changed peaks");
   a_timer_flags: assert property (@(posedge clock) disable iff (!rst_n) // R8
      1'b1 |=> disp_val[2:0] == $past({gpt_running, nrt_running,
                                       mrt_running}))
      else $error("timer flags mismatch");
   a_read_ctrl: assert property (@(posedge clock) disable iff (!rst_n) // R17
      (rd && addr == REG_CTRL_OFS) |=> rdata == $past(ctrl))
      else $error("control readback mismatch");

   // ------------------------------------------------------------
   // Control register checks
   // ------------------------------------------------------------
   // A write to the control register lands at the next edge.
   a_src_write: assert property (@(posedge clock) disable iff (!rst_n) // R1
      (rst_n && wr && addr == REG_CTRL_OFS && !set_default)
      |=> ctrl[CTRL_SRC_BIT] == $past(wdata[CTRL_SRC_BIT]))
      else $error("source select not written");
   a_code_write: assert property (@(posedge clock) disable iff (!rst_n) // R2
      (rst_n && wr && addr == REG_CTRL_OFS && !set_default)
      |=> ctrl[CTRL_CODE_HI:CTRL_CODE_LO]
       == $past(wdata[CTRL_CODE_HI:CTRL_CODE_LO]))
      else $error("software code not written");
   a_meas_write: assert property (@(posedge clock) disable iff (!rst_n) // R3
      (rst_n && wr && addr == REG_CTRL_OFS && !set_default)
      |=> ctrl[CTRL_MEAS_HI:CTRL_MEAS_LO]
       == $past(wdata[CTRL_MEAS_HI:CTRL_MEAS_LO]))
      else $error("measure field not written");
   // Writes elsewhere, display and signal strength included, leave it alone.
   a_ctrl_hold: assert property (@(posedge clock) disable iff (!rst_n) // R17
      (rst_n && !(wr && addr == REG_CTRL_OFS) && !set_default)
      |=> $stable(ctrl))
      else $error("control changed without write");
   a_meas_default: assert property (@(posedge clock) // R4
      (!rst_n || set_default) |=> measure_supply_select == MEAS_MAIN)
      else $error("measure select not cleared");

   // ------------------------------------------------------------
   // Regulator code checks
   // ------------------------------------------------------------
   a_src_auto: assert property (@(posedge clock) disable iff (!rst_n) // R1
      (rst_n && !ctrl[CTRL_SRC_BIT] && !set_default)
      |=> reg_code == $past(adj_code))
      else $error("adjust result not applied");
   a_adjust_load: assert property (@(posedge clock) disable iff (!rst_n) // R1
      (rst_n && adjust_done && !set_default)
      |=> adj_code == $past(adjust_code))
      else $error("adjust result not stored");
   a_adjust_default: assert property (@(posedge clock) // R6
      (!rst_n || set_default) |=> adj_code == REG_CODE_MAX)
      else $error("adjust result not at maximum");
   // A valid software code never turns into an unused one on the way out.
   a_code_valid: assert property (@(posedge clock) disable iff (!rst_n) // R7
      (rst_n && ctrl[CTRL_SRC_BIT] && !set_default
       && ctrl[CTRL_CODE_HI:CTRL_CODE_LO] >= REG_CODE_MIN)
      |=> reg_code >= REG_CODE_MIN)
      else $error("valid code lost");
   a_disp_code: assert property (@(posedge clock) disable iff (!rst_n) // R5
      (rst_n && rd && addr == REG_DISP_OFS)
      |=> rdata[7:4] == $past(reg_code))
      else $error("displayed code mismatch");
   a_disp_gap: assert property (@(posedge clock) disable iff (!rst_n) // R21
      (rst_n && rd && addr == REG_DISP_OFS) |=> rdata[3] == 1'b0)
      else $error("display bit 3 set");

   // ------------------------------------------------------------
   // Timer flag checks
   // ------------------------------------------------------------
   // A read shows the flags that stood two edges before the data.
   a_gpt_flag: assert property (@(posedge clock) disable iff (!rst_n) // R8
      (rst_n && $past(rst_n) && rd && addr == REG_DISP_OFS)
      |=> rdata[2] == $past(gpt_running, 2))
      else $error("general purpose flag mismatch");
   a_nrt_flag: assert property (@(posedge clock) disable iff (!rst_n) // R9
      (rst_n && $past(rst_n) && rd && addr == REG_DISP_OFS)
      |=> rdata[1] == $past(nrt_running, 2))
      else $error("no-response flag mismatch");
   a_mrt_flag: assert property (@(posedge clock) disable iff (!rst_n) // R10
      (rst_n && $past(rst_n) && rd && addr == REG_DISP_OFS)
      |=> rdata[0] == $past(mrt_running, 2))
      else $error("mask receive flag mismatch");

   // ------------------------------------------------------------
   // Peak signal strength checks
   // ------------------------------------------------------------
   a_rssi_default: assert property (@(posedge clock) // R14
      (!rst_n || set_default) |=> rssi_val == RSSI_RESET)
      else $error("peaks not cleared by default");
   a_amp_read: assert property (@(posedge clock) disable iff (!rst_n) // R11
      (rst_n && rd && addr == REG_RSSI_OFS)
      |=> rdata[7:4] == $past(amplitude_chan_peak))
      else $error("amplitude peak readback mismatch");
   a_phase_read: assert property (@(posedge clock) disable iff (!rst_n) // R12
      (rst_n && rd && addr == REG_RSSI_OFS)
      |=> rdata[3:0] == $past(phase_chan_peak))
      else $error("phase peak readback mismatch");
   a_amp_peak: assert property (@(posedge clock) disable iff (!rst_n) // R20
      (rst_n && amp_valid && !set_default && !clear_rssi && !msg_start)
      |=> amplitude_chan_peak >= $past(amp_code))
      else $error("amplitude sample above peak");
   a_phase_peak: assert property (@(posedge clock) disable iff (!rst_n) // R20
      (rst_n && phase_valid && !set_default && !clear_rssi && !msg_start)
      |=> phase_chan_peak >= $past(phase_code))
      else $error("phase sample above peak");
   // Without a sample, a peak holds until a clear.
   a_amp_idle: assert property (@(posedge clock) disable iff (!rst_n) // R20
      (rst_n && !amp_valid && !set_default && !clear_rssi && !msg_start)
      |=> $stable(amplitude_chan_peak))
      else $error("amplitude peak moved without sample");
   a_phase_idle: assert property (@(posedge clock) disable iff (!rst_n) // R20
      (rst_n && !phase_valid && !set_default && !clear_rssi && !msg_start)
      |=> $stable(phase_chan_peak))
      else $error("phase peak moved without sample");
   // A larger code is taken as it is, so codes keep their order.
   a_amp_take: assert property (@(posedge clock) disable iff (!rst_n) // R16
      (rst_n && amp_valid && amp_code > amplitude_chan_peak
       && !set_default && !clear_rssi && !msg_start)
      |=> amplitude_chan_peak == $past(amp_code))
      else $error("amplitude peak not taken");
   a_phase_take: assert property (@(posedge clock) disable iff (!rst_n) // R16
      (rst_n && phase_valid && phase_code > phase_chan_peak
       && !set_default && !clear_rssi && !msg_start)
      |=> phase_chan_peak == $past(phase_code))
      else $error("phase peak not taken");

   // ------------------------------------------------------------
   // Channel select and read path checks
   // ------------------------------------------------------------
   a_chan_follow: assert property (@(posedge clock) disable iff (!rst_n) // R15
      rst_n |=> chan_sel == $past(phase_chan_sel))
      else $error("channel select lags");
   a_aux_read: assert property (@(posedge clock) disable iff (!rst_n) // R19
      (rst_n && rd && addr == REG_AUX_OFS)
      |=> rdata == {$past(chan_sel), 7'h00})
      else $error("auxiliary readback mismatch");
   // Read data stand for one cycle only; idle cycles read zero.
   a_rdata_idle: assert property (@(posedge clock) disable iff (!rst_n) // R17
      (rst_n && !rd) |=> rdata == 8'h00)
      else $error("read data not idle");
   a_unmapped_read: assert property (@(posedge clock) disable iff (!rst_n) // R21
      (rst_n && rd && addr != REG_CTRL_OFS && addr != REG_DISP_OFS
       && addr != REG_RSSI_OFS && addr != REG_AUX_OFS) |=> rdata == 8'h00)
      else $error("unmapped read not zero");

endmodule : rrd_regs

// File: rrd_pkg.sv
// Purpose: Constants for the regulator, timer display and signal strength
//          register slice.
// Assumes: Eight-bit registers on a byte-addressed host port.
// Notes:   Offsets are byte addresses on the host port.
package rrd_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] REG_CTRL_OFS = 8'h2A;
   localparam logic [7:0] REG_DISP_OFS = 8'h2B;
   localparam logic [7:0] REG_RSSI_OFS = 8'h2C;
   localparam logic [7:0] REG_AUX_OFS = 8'h30;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] RSSI_RESET = 8'h00;
   localparam logic [3:0] REG_CODE_MAX = 4'hF;
   localparam logic [3:0] REG_CODE_MIN = 4'h5;
   localparam int CTRL_SRC_BIT = 7;
   localparam int CTRL_CODE_HI = 6;
   localparam int CTRL_CODE_LO = 3;
   localparam int CTRL_MEAS_HI = 2;
   localparam int CTRL_MEAS_LO = 1;
   localparam logic [1:0] MEAS_MAIN = 2'h0;
   localparam logic [1:0] MEAS_ANALOG = 2'h1;
   localparam logic [1:0] MEAS_DIGITAL = 2'h2;
   localparam logic [1:0] MEAS_RF = 2'h3;
endpackage : rrd_pkg

// File: rrd_regs_bench.sv
// Purpose: Self-checking bench for the regulator and peak strength registers.
// Assumes: Read data stand in the cycle after the read strobe.
// Notes:   Control writes run from a table; commands are tested by hand.
`timescale 1ns/1ps
module rrd_regs_bench;
   import rrd_pkg::*;
   typedef struct packed {
      logic [7:0] wd;
      logic [7:0] rb;
      logic [1:0] sel;
      logic [3:0] code;
      logic [2:0] tmr;
   } rrd_row_s;
   logic clock, rst_n, wr, rd, set_default, clear_rssi, msg_start;
   logic adjust_done, amp_valid, phase_valid, phase_chan_sel;
   logic gpt_running, nrt_running, mrt_running;
   logic [7:0] addr, wdata, rdata;
   logic [3:0] adjust_code, amp_code, phase_code, reg_code;
   logic [1:0] measure_supply_select;
   int err_total = 0;
   int n_checks = 0;
   rrd_row_s rows [4] = '{'{8'hAB, 8'hAA, 2'h1, 4'h5, 3'h4},
      '{8'hFC, 8'hFC, 2'h2, 4'hF, 3'h2}, '{8'hC6, 8'hC6, 2'h3, 4'h8, 3'h1},
      '{8'h38, 8'h38, 2'h0, 4'h9, 3'h7}};

   rrd_regs u_dut (.clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
      .set_default, .clear_rssi, .msg_start, .adjust_done, .adjust_code,
      .amp_valid, .amp_code, .phase_valid, .phase_code, .phase_chan_sel,
      .gpt_running, .nrt_running, .mrt_running, .reg_code,
      .measure_supply_select);

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rreg
   // Command 0 set-default, 1 clear peaks, 2 message start, 3 adjust.
   task automatic pulse(input int k);
      @(posedge clock);
      set_default <= (k == 0);
      clear_rssi <= (k == 1);
      msg_start <= (k == 2);
      adjust_done <= (k == 3);
      @(posedge clock);
      {set_default, clear_rssi, msg_start, adjust_done} <= 4'h0;
   endtask : pulse
   task automatic samp(input logic [3:0] a, input logic [3:0] p);
      @(posedge clock);
      {amp_valid, phase_valid, amp_code, phase_code} <= {2'h3, a, p};
      @(posedge clock);
      {amp_valid, phase_valid} <= 2'h0;
   endtask : samp
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results

   // ------------------------------------------------------------
   // Clock, watchdog and tests
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      repeat (3000) @(posedge clock);
      err_total++;
      results();
   end
   initial begin
      {rst_n, wr, rd, set_default, clear_rssi, msg_start} = 6'h0;
      {adjust_done, amp_valid, phase_valid, phase_chan_sel} = 4'h0;
      {gpt_running, nrt_running, mrt_running} = 3'h0;
      {addr, wdata, amp_code, phase_code} = 24'h0;
      adjust_code = 4'h9;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      rreg(REG_CTRL_OFS, CTRL_RESET);
      rreg(REG_DISP_OFS, 8'hF0);
      rreg(REG_RSSI_OFS, RSSI_RESET);
      rreg(REG_AUX_OFS, 8'h00);
      $display("reset test done");
      pulse(3);
      foreach (rows[i]) begin
         {gpt_running, nrt_running, mrt_running} <= rows[i].tmr;
         wreg(REG_CTRL_OFS, rows[i].wd);
         repeat (2) @(posedge clock);
         #1 chk({6'h0, measure_supply_select}, {6'h0, rows[i].sel});
         chk({4'h0, reg_code}, {4'h0, rows[i].code});
         rreg(REG_CTRL_OFS, rows[i].rb);
         rreg(REG_DISP_OFS, {rows[i].code, 1'b0, rows[i].tmr});
      end
      $display("control table done");
      samp(4'h3, 4'h9);
      samp(4'h7, 4'h2);
      samp(4'h5, 4'h0);
      wreg(REG_RSSI_OFS, 8'hFF);
      rreg(REG_RSSI_OFS, 8'h79);
      phase_chan_sel <= 1'b1;
      @(posedge clock);
      rreg(REG_AUX_OFS, 8'h80);
      pulse(2);
      rreg(REG_RSSI_OFS, 8'h00);
      samp(4'h2, 4'h4);
      pulse(1);
      rreg(REG_RSSI_OFS, 8'h00);
      rreg(8'h40, 8'h00);
      wreg(REG_DISP_OFS, 8'h0F);
      rreg(REG_DISP_OFS, 8'h97);
      samp(4'h6, 4'h6);
      pulse(0);
      rreg(REG_CTRL_OFS, 8'h00);
      rreg(REG_RSSI_OFS, 8'h00);
      rreg(REG_DISP_OFS, 8'hF7);
      $display("peak and command tests done");
      results();
   end
endmodule : rrd_regs_bench
